// [design/htu_pkg.sv]
// package for the two-channel hysteresis trigger unit
// assumes 8-bit unsigned samples, 32 codes per vertical division, 100 MHz clk_sys
package htu_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;   // start, source, hysteresis, time-out
  localparam logic [7:0] ADDR_SLOPE = 8'h04;  // any write toggles slope
  localparam logic [7:0] ADDR_LEVEL1 = 8'h08; // trigger level, first channel
  localparam logic [7:0] ADDR_LEVEL2 = 8'h0c; // trigger level, second channel
  localparam logic [7:0] ADDR_OFFS1 = 8'h10;  // offset, first channel
  localparam logic [7:0] ADDR_OFFS2 = 8'h14;  // offset, second channel
  localparam logic [7:0] ADDR_STATUS = 8'h18; // read-only state
  // ==========================================================
  // ctrl field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_SRC_LO = 1;
  localparam int CTRL_HYS_LO = 4;
  localparam int CTRL_TMO_LO = 8;
  // status field positions
  localparam int ST_BUSY = 0;
  localparam int ST_ARM1 = 1;
  localparam int ST_ARM2 = 2;
  localparam int ST_FIRED1 = 3;
  localparam int ST_FIRED2 = 4;
  localparam int ST_TIMEOUT = 5;
  localparam int ST_SLOPE = 6;
  localparam int ST_REC_LO = 16;
  // ==========================================================
  // reset values and response codes
  localparam logic [7:0] LEVEL_RST = 8'h80;
  localparam logic [7:0] OFFS_RST = 8'h00;
  localparam logic [3:0] HYS_RST = 4'h2;
  localparam logic [3:0] TMO_RST = 4'hb;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // geometry
  localparam int CODES_PER_DIV = 32;        // sample codes per vertical division
  localparam int EIGHTH_CODES = CODES_PER_DIV / 8;
  localparam int SAMPLES_PER_DIV = 50;      // samples per horizontal division
  localparam int DIVS_PER_PAGE = 10;
  localparam logic [9:0] PAGE_SAMPLES = 10'(SAMPLES_PER_DIV * DIVS_PER_PAGE);
  localparam logic [3:0] TMO_INFINITE = 4'hb; // index of the endless time-out
  // source select codes
  typedef enum logic [2:0] {
    source_first_channel,
    source_second_channel,
    source_both_channels,
    source_either_channel,
    source_outside_input
  } htu_src_e;
  // acquisition states
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_WAIT, ACQ_POST} htu_acq_e;
endpackage

// [design/htu_chan.sv]
// one channel comparator: arming and firing thresholds with hysteresis
// assumes samples arrive with a one-cycle valid strobe on clk_sys
module htu_chan (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic sample_valid,
  input wire logic [7:0] sample,
  input wire logic [7:0] level,
  input wire logic [7:0] hyst,
  input wire logic slope_fall,
  output logic armed,
  output logic fire
);
  // ==========================================================
  // state
  typedef struct packed {
    logic armed;
    logic fire;
    logic have_prev;
    logic [7:0] prev;
  } htu_chan_s;
  htu_chan_s cur_ff, nxt_ff;
  logic [8:0] arm_wide; // arming threshold before clamping
  logic [7:0] arm_th;   // arming threshold
  logic arm_x;          // arming crossing this sample
  logic fire_x;         // firing crossing this sample

  // ==========================================================
  // thresholds and crossings
  always_comb begin
    // fire at the level, arm one hysteresis away on the approach side
    if (slope_fall) begin
      arm_wide = {1'b0, level} + {1'b0, hyst}; // above the level
      arm_th = arm_wide[8] ? 8'hff : arm_wide[7:0];
      arm_x = cur_ff.prev > arm_th && sample <= arm_th;
      fire_x = cur_ff.prev > level && sample <= level;
    end else begin
      arm_wide = {1'b0, level} - {1'b0, hyst}; // below the level
      arm_th = arm_wide[8] ? 8'h00 : arm_wide[7:0];
      arm_x = cur_ff.prev < arm_th && sample >= arm_th;
      fire_x = cur_ff.prev < level && sample >= level;
    end
    nxt_ff = cur_ff;
    nxt_ff.fire = 1'b0;
    if (!enable) begin
      // cleared outside the waiting phase
      nxt_ff.armed = 1'b0;
      nxt_ff.have_prev = 1'b0;
    end else if (sample_valid) begin
      nxt_ff.prev = sample;
      nxt_ff.have_prev = 1'b1;
      if (cur_ff.have_prev) begin
        if ((cur_ff.armed || arm_x) && fire_x) begin
          nxt_ff.fire = 1'b1; // one pulse, then disarm
          nxt_ff.armed = 1'b0;
        end else if (arm_x) begin
          nxt_ff.armed = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // register the state, synchronous reset to disarmed
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign armed = cur_ff.armed;
  assign fire = cur_ff.fire;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_fire_needs_cross: assert property (fire |-> $past(fire_x) && $past(sample_valid))
    else $error("fire without firing crossing");
  a_arm_clears_off: assert property (!enable |=> !armed && !fire)
    else $error("channel active while disabled");
endmodule

// [design/htu_top.sv]
// trigger unit top: AXI4-Lite registers, source select, time-out, record pages
// assumes record memory outside takes wr_en/wr_addr/wr_data1/wr_data2 each cycle
// ==========================================================
module htu_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_valid,
  input wire logic [7:0] sample_first,
  input wire logic [7:0] sample_second,
  input wire logic ext_trigger,
  output logic trig_pulse,
  output logic record_done,
  output logic wr_en,
  output logic [9:0] wr_addr,
  output logic [7:0] wr_data1,
  output logic [7:0] wr_data2
);
  // ==========================================================
  // state
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [2:0] src;
    logic [3:0] hys_idx;
    logic [3:0] tmo_idx;
    logic slope;
    logic [7:0] level1;
    logic [7:0] level2;
    logic [7:0] offs1;
    logic [7:0] offs2;
    htu_pkg::htu_acq_e acq;
    logic [9:0] page_cnt;
    logic [18:0] tmo_cnt;
    logic fired1;
    logic fired2;
    logic timed_out;
    logic ext_prev;
    logic trig;
    logic done;
    logic wr_en;
    logic [9:0] wr_addr;
    logic [7:0] wr_d1;
    logic [7:0] wr_d2;
    logic [15:0] records;
  } htu_top_s;
  htu_top_s cur_ff, nxt_ff;

  logic [1:0] ch_armed;   // per-channel armed
  logic [1:0] ch_fire;    // per-channel fire pulse
  logic [7:0] hyst_codes; // selected hysteresis in sample codes
  logic [18:0] tmo_limit; // selected time-out in samples
  logic [31:0] wmask;     // written word merged lanes
  logic [31:0] st_word;   // status read value
  logic src_hit;          // selected source satisfied
  logic ext_edge;         // outside input edge in slope direction
  logic do_write;         // write address and data both present
  logic [7:0] w_byte;     // low byte of merged write
  logic start_now;        // a start bit lands this cycle; a restart beats the running sequence

  // ==========================================================
  // lookups
  // hysteresis in eighths of a division
  function automatic logic [7:0] hys_codes(input logic [3:0] idx);
    logic [4:0] eighths;
    case (idx)
      4'h0: eighths = 5'h00;
      4'h1: eighths = 5'h01;
      4'h2: eighths = 5'h02;
      4'h3: eighths = 5'h04;
      4'h4: eighths = 5'h06;
      4'h5: eighths = 5'h08;
      4'h6: eighths = 5'h0a;
      4'h7: eighths = 5'h0c;
      4'h8: eighths = 5'h0e;
      4'h9: eighths = 5'h10;
      4'ha: eighths = 5'h12;
      4'hb: eighths = 5'h14;
      default: eighths = 5'h14;
    endcase
    hys_codes = 8'(eighths * htu_pkg::EIGHTH_CODES);
  endfunction

  // time-out in samples, divisions times samples per division
  function automatic logic [18:0] tmo_samples(input logic [3:0] idx);
    logic [13:0] divs;
    case (idx)
      4'h0: divs = 14'h0000;
      4'h1: divs = 14'h000a;
      4'h2: divs = 14'h0014;
      4'h3: divs = 14'h0032;
      4'h4: divs = 14'h0064;
      4'h5: divs = 14'h00c8;
      4'h6: divs = 14'h01f4;
      4'h7: divs = 14'h03e8;
      4'h8: divs = 14'h07d0;
      4'h9: divs = 14'h1388;
      4'ha: divs = 14'h2710;
      default: divs = 14'h0000;
    endcase
    tmo_samples = 19'(divs * htu_pkg::SAMPLES_PER_DIV);
  endfunction

  // byte-lane merge of a write into an old register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // ==========================================================
  // two channel comparators, enabled only while waiting for a trigger
  logic [7:0] ch_sample [2];
  logic [7:0] ch_level [2];
  assign ch_sample[0] = sample_first;
  assign ch_sample[1] = sample_second;
  assign ch_level[0] = cur_ff.level1;
  assign ch_level[1] = cur_ff.level2;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      htu_chan u_chan (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(cur_ff.acq == htu_pkg::ACQ_WAIT),
        .sample_valid(sample_valid),
        .sample(ch_sample[g]),
        .level(ch_level[g]),
        .hyst(hyst_codes),
        .slope_fall(cur_ff.slope),
        .armed(ch_armed[g]),
        .fire(ch_fire[g])
      );
    end
  endgenerate

  // ==========================================================
  // next-state logic
  always_comb begin
    hyst_codes = hys_codes(cur_ff.hys_idx);
    tmo_limit = tmo_samples(cur_ff.tmo_idx);
    do_write = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
    wmask = lane_merge(32'h0000_0000, cur_ff.w_data, cur_ff.w_strb);
    w_byte = wmask[7:0];
    start_now = do_write && ({cur_ff.aw_addr[7:2], 2'b00} == htu_pkg::ADDR_CTRL) &&
                wmask[htu_pkg::CTRL_START];
    // outside input edge, rising or falling per slope
    ext_edge = cur_ff.slope ? (cur_ff.ext_prev && !ext_trigger)
                            : (!cur_ff.ext_prev && ext_trigger);
    st_word = '0;
    st_word[htu_pkg::ST_BUSY] = cur_ff.acq != htu_pkg::ACQ_IDLE;
    st_word[htu_pkg::ST_ARM1] = ch_armed[0];
    st_word[htu_pkg::ST_ARM2] = ch_armed[1];
    st_word[htu_pkg::ST_FIRED1] = cur_ff.fired1;
    st_word[htu_pkg::ST_FIRED2] = cur_ff.fired2;
    st_word[htu_pkg::ST_TIMEOUT] = cur_ff.timed_out;
    st_word[htu_pkg::ST_SLOPE] = cur_ff.slope; // current slope readable
    st_word[htu_pkg::ST_REC_LO +: 16] = cur_ff.records;
    // source selection
    case (htu_pkg::htu_src_e'(cur_ff.src))
      htu_pkg::source_first_channel: src_hit = ch_fire[0];
      htu_pkg::source_second_channel: src_hit = ch_fire[1];
      htu_pkg::source_both_channels: src_hit = (cur_ff.fired1 || ch_fire[0]) &&
                                               (cur_ff.fired2 || ch_fire[1]);
      htu_pkg::source_either_channel: src_hit = ch_fire[0] || ch_fire[1];
      htu_pkg::source_outside_input: src_hit = ext_edge;
      default: src_hit = 1'b0;
    endcase

    nxt_ff = cur_ff;
    nxt_ff.trig = 1'b0;
    nxt_ff.done = 1'b0;
    nxt_ff.wr_en = 1'b0;
    nxt_ff.ext_prev = ext_trigger;

    // write channels: take address and data in either order
    if (!cur_ff.aw_got && s_axi_awvalid) begin
      nxt_ff.aw_got = 1'b1;
      nxt_ff.aw_addr = s_axi_awaddr;
    end
    if (!cur_ff.w_got && s_axi_wvalid) begin
      nxt_ff.w_got = 1'b1;
      nxt_ff.w_data = s_axi_wdata;
      nxt_ff.w_strb = s_axi_wstrb;
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_ff.bvalid = 1'b0;
    end
    if (do_write) begin
      nxt_ff.aw_got = 1'b0;
      nxt_ff.w_got = 1'b0;
      nxt_ff.bvalid = 1'b1;
      nxt_ff.bresp = htu_pkg::RESP_OKAY;
      case ({cur_ff.aw_addr[7:2], 2'b00})
        htu_pkg::ADDR_CTRL: begin
          if (cur_ff.w_strb[0]) begin
            nxt_ff.src = wmask[htu_pkg::CTRL_SRC_LO +: 3];
            nxt_ff.hys_idx = wmask[htu_pkg::CTRL_HYS_LO +: 4];
          end
          if (cur_ff.w_strb[1]) begin
            nxt_ff.tmo_idx = wmask[htu_pkg::CTRL_TMO_LO +: 4];
          end
          if (wmask[htu_pkg::CTRL_START]) begin
            // new acquisition: pre page first, latches cleared
            nxt_ff.acq = htu_pkg::ACQ_PRE;
            nxt_ff.page_cnt = '0;
            nxt_ff.tmo_cnt = '0;
            nxt_ff.fired1 = 1'b0;
            nxt_ff.fired2 = 1'b0;
            nxt_ff.timed_out = 1'b0;
          end
        end
        htu_pkg::ADDR_SLOPE: nxt_ff.slope = !cur_ff.slope;
        htu_pkg::ADDR_LEVEL1: if (cur_ff.w_strb[0]) nxt_ff.level1 = w_byte;
        htu_pkg::ADDR_LEVEL2: if (cur_ff.w_strb[0]) nxt_ff.level2 = w_byte;
        htu_pkg::ADDR_OFFS1: begin
          if (cur_ff.w_strb[0]) begin
            nxt_ff.offs1 = w_byte;
            nxt_ff.level1 = cur_ff.level1 + w_byte - cur_ff.offs1;
          end
        end
        htu_pkg::ADDR_OFFS2: begin
          if (cur_ff.w_strb[0]) begin
            nxt_ff.offs2 = w_byte;
            nxt_ff.level2 = cur_ff.level2 + w_byte - cur_ff.offs2;
          end
        end
        htu_pkg::ADDR_STATUS: nxt_ff.bresp = htu_pkg::RESP_OKAY;
        default: nxt_ff.bresp = htu_pkg::RESP_SLVERR;
      endcase
    end

    // read channel: answer one cycle after the address is taken
    if (cur_ff.rvalid && s_axi_rready) begin
      nxt_ff.rvalid = 1'b0;
    end
    if (!cur_ff.rvalid && s_axi_arvalid) begin
      nxt_ff.rvalid = 1'b1;
      nxt_ff.rresp = htu_pkg::RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        htu_pkg::ADDR_CTRL: nxt_ff.rdata = 32'({cur_ff.tmo_idx, cur_ff.hys_idx,
                                               cur_ff.src, 1'b0});
        htu_pkg::ADDR_SLOPE: nxt_ff.rdata = 32'(cur_ff.slope);
        htu_pkg::ADDR_LEVEL1: nxt_ff.rdata = 32'(cur_ff.level1);
        htu_pkg::ADDR_LEVEL2: nxt_ff.rdata = 32'(cur_ff.level2);
        htu_pkg::ADDR_OFFS1: nxt_ff.rdata = 32'(cur_ff.offs1);
        htu_pkg::ADDR_OFFS2: nxt_ff.rdata = 32'(cur_ff.offs2);
        htu_pkg::ADDR_STATUS: nxt_ff.rdata = st_word;
        default: begin
          nxt_ff.rdata = '0;
          nxt_ff.rresp = htu_pkg::RESP_SLVERR;
        end
      endcase
    end

    // acquisition sequence, one record address per sample
    if (sample_valid && cur_ff.acq != htu_pkg::ACQ_IDLE) begin
      nxt_ff.wr_d1 = sample_first;
      nxt_ff.wr_d2 = sample_second;
    end
    // a start decoded above restarts at once, so the old sequence is skipped
    case (start_now ? htu_pkg::ACQ_IDLE : cur_ff.acq)
      htu_pkg::ACQ_IDLE: nxt_ff.wr_en = 1'b0; // nothing recorded, start values kept
      htu_pkg::ACQ_PRE: begin
        if (sample_valid) begin
          // fill the pre page once before trigger may be seen
          nxt_ff.wr_en = 1'b1;
          nxt_ff.wr_addr = cur_ff.page_cnt;
          nxt_ff.page_cnt = cur_ff.page_cnt + 10'h001;
          if (cur_ff.page_cnt == htu_pkg::PAGE_SAMPLES - 10'h001) begin
            nxt_ff.page_cnt = '0;
            nxt_ff.acq = htu_pkg::ACQ_WAIT;
          end
        end
      end
      htu_pkg::ACQ_WAIT: begin
        if (ch_fire[0]) nxt_ff.fired1 = 1'b1; // held until the next start
        if (ch_fire[1]) nxt_ff.fired2 = 1'b1;
        if (sample_valid) begin
          // pre page kept as a ring until the trigger
          nxt_ff.wr_en = 1'b1;
          nxt_ff.wr_addr = cur_ff.page_cnt;
          nxt_ff.page_cnt = (cur_ff.page_cnt == htu_pkg::PAGE_SAMPLES - 10'h001) ? '0
                            : cur_ff.page_cnt + 10'h001;
          nxt_ff.tmo_cnt = cur_ff.tmo_cnt + 19'h00001;
        end
        if (src_hit) begin
          nxt_ff.trig = 1'b1;
          nxt_ff.acq = htu_pkg::ACQ_POST;
          nxt_ff.page_cnt = '0;
        end else if (cur_ff.tmo_idx != htu_pkg::TMO_INFINITE &&
                     cur_ff.tmo_cnt >= tmo_limit) begin
          nxt_ff.timed_out = 1'b1; // end the wait without trigger
          nxt_ff.acq = htu_pkg::ACQ_POST;
          nxt_ff.page_cnt = '0;
        end
      end
      htu_pkg::ACQ_POST: begin
        if (sample_valid) begin
          nxt_ff.wr_en = 1'b1;
          nxt_ff.wr_addr = htu_pkg::PAGE_SAMPLES + cur_ff.page_cnt;
          nxt_ff.page_cnt = cur_ff.page_cnt + 10'h001;
          if (cur_ff.page_cnt == htu_pkg::PAGE_SAMPLES - 10'h001) begin
            // only here is a record delivered
            nxt_ff.done = 1'b1;
            nxt_ff.records = cur_ff.records + 16'h0001;
            nxt_ff.acq = htu_pkg::ACQ_IDLE;
          end
        end
      end
      default: nxt_ff.acq = htu_pkg::ACQ_IDLE;
    endcase
  end

  // ==========================================================
  // register the whole state, synchronous active-low reset
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cur_ff <= '0; // idle, disarmed
      cur_ff.hys_idx <= htu_pkg::HYS_RST;
      cur_ff.tmo_idx <= htu_pkg::TMO_RST;
      cur_ff.level1 <= htu_pkg::LEVEL_RST;
      cur_ff.level2 <= htu_pkg::LEVEL_RST;
      cur_ff.offs1 <= htu_pkg::OFFS_RST;
      cur_ff.offs2 <= htu_pkg::OFFS_RST;
      cur_ff.acq <= htu_pkg::ACQ_IDLE;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready = !cur_ff.aw_got;
  assign s_axi_wready = !cur_ff.w_got;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_arready = !cur_ff.rvalid;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rresp = cur_ff.rresp;
  assign s_axi_rdata = cur_ff.rdata;
  assign trig_pulse = cur_ff.trig;
  assign record_done = cur_ff.done;
  assign wr_en = cur_ff.wr_en;
  assign wr_addr = cur_ff.wr_addr;
  assign wr_data1 = cur_ff.wr_d1;
  assign wr_data2 = cur_ff.wr_d2;

  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_waiting;
    cur_ff.acq == htu_pkg::ACQ_WAIT;
  endsequence
  sequence s_to_post;
    ##1 cur_ff.acq == htu_pkg::ACQ_POST;
  endsequence
  a_trig_from_wait: assert property (trig_pulse |-> $past(cur_ff.acq) == htu_pkg::ACQ_WAIT)
    else $error("trigger pulse outside waiting");
  a_trig_single: assert property (trig_pulse |=> !trig_pulse)
    else $error("trigger pulse longer than one cycle");
  a_and_needs_both: assert property (s_waiting and !cur_ff.fired2 && !ch_fire[1] &&
      cur_ff.src == 3'(htu_pkg::source_both_channels) |=> !trig_pulse)
    else $error("both-mode trigger with a channel unfired");
  a_or_any_fires: assert property (s_waiting and cur_ff.src == 3'(htu_pkg::source_either_channel)
      && (ch_fire != 2'b00) && !start_now |-> s_to_post)
    else $error("either-mode fire missed");
  a_infinite_waits: assert property (s_waiting and cur_ff.tmo_idx == htu_pkg::TMO_INFINITE &&
      !src_hit |=> !cur_ff.timed_out)
    else $error("infinite time-out expired");
  a_tmo_ends_wait: assert property (s_waiting and cur_ff.tmo_idx != htu_pkg::TMO_INFINITE &&
      cur_ff.tmo_cnt >= tmo_limit && !start_now |-> s_to_post)
    else $error("time-out did not end the wait");
  a_done_from_post: assert property (record_done |-> $past(cur_ff.acq) == htu_pkg::ACQ_POST &&
      $past(cur_ff.page_cnt) == htu_pkg::PAGE_SAMPLES - 10'h001)
    else $error("record delivered early");
  a_slope_toggles: assert property (do_write && cur_ff.aw_addr == htu_pkg::ADDR_SLOPE |=>
      cur_ff.slope != $past(cur_ff.slope))
    else $error("slope write did not toggle");
  a_offs_moves_lvl: assert property (do_write && cur_ff.aw_addr == htu_pkg::ADDR_OFFS1 &&
      cur_ff.w_strb[0] |=> cur_ff.level1 - cur_ff.offs1 ==
      $past(cur_ff.level1) - $past(cur_ff.offs1))
    else $error("offset write lost the trigger point");
  a_post_addr: assert property (wr_en && $past(cur_ff.acq) == htu_pkg::ACQ_POST |->
      wr_addr >= htu_pkg::PAGE_SAMPLES)
    else $error("post page address in pre page");
endmodule

// [sim/htu_afe.sv]
// sample source standing in for the two-channel digitiser
// assumes clk_sys and reset_n of the trigger unit; levels come from the bench
module htu_afe (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] lvl1,
  input wire logic [7:0] lvl2,
  output logic sample_valid,
  output logic [7:0] sample_first,
  output logic [7:0] sample_second
);
  timeunit 1ns;
  timeprecision 1ps;
  // strobe every other cycle; between strobes the data lines show inverted levels
  always_ff @(posedge clk_sys) begin
    sample_valid <= reset_n && !sample_valid;
    sample_first <= !sample_valid ? lvl1 : ~lvl1;
    sample_second <= !sample_valid ? lvl2 : ~lvl2;
  end
endmodule

// [sim/htu_bench.sv]
// self-checking bench for the trigger unit: register access and whole acquisitions
// assumes htu_pkg, htu_top and the htu_afe sample source are compiled first
module htu_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bench-driven inputs, all given a value at time zero
  logic clk_sys = 1'b0, reset_n = 1'b0, ext_trigger = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lvl1 = 8'h10, lvl2 = 8'h10;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  // design and sample-source outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_valid, trig_pulse, record_done, wr_en;
  logic [7:0] sample_first, sample_second, wr_data1, wr_data2;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] wr_addr;
  int bad_count = 0, total_checks = 0, ntrig = 0;
  htu_top dut (.*);
  htu_afe afe (.*);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // count trigger pulses of the running acquisition
  always @(posedge clk_sys) begin
    if (trig_pulse === 1'b1) ntrig++;
  end
  // one counted comparison; a mismatch is printed at once
  task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // write one word, address and data offered together, response compared
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bvalid", s_axi_bvalid, 1'b1);
    chk("bresp", s_axi_bresp, r);
  endtask
  // read one word; response code and data compared together
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk("rvalid", s_axi_rvalid, 1'b1);
    chk("rresp_rdata", {s_axi_rresp, s_axi_rdata}, e);
  endtask
  // one acquisition: start level through the pre page, then step levels in the wait phase
  task automatic acq(input logic [31:0] c, input logic [7:0] s0, v1, v2, input logic x,
                     input int t, input int ns);
    int n;
    lvl1 <= s0;
    lvl2 <= s0;
    ext_trigger <= 1'b0;
    wr(htu_pkg::ADDR_CTRL, c, htu_pkg::RESP_OKAY);
    ntrig = 0;
    n = 0;
    repeat (3000) begin
      @(posedge clk_sys);
      if (wr_en === 1'b1) n++;
      if (wr_en === 1'b1 && wr_addr === 10'h1f3) break;
    end
    // let the first wait-phase samples prime the comparators
    repeat (8) begin
      @(posedge clk_sys);
      if (wr_en === 1'b1) n++;
    end
    lvl1 <= v1;
    lvl2 <= v2;
    ext_trigger <= x;
    repeat (3000) begin
      @(posedge clk_sys);
      if (wr_en === 1'b1) n++;
      if (record_done === 1'b1) break;
    end
    chk("done_addr", {record_done, wr_addr}, 34'h7e7);
    chk("pulses", ntrig, t);
    chk("rec_data", {wr_data1, wr_data2}, {v1, v2});
    // samples written: two pages plus the wait, only where the wait length is known
    if (ns > 0) chk("samples", n, ns);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(htu_pkg::ADDR_CTRL, 34'hb20);
    rd(htu_pkg::ADDR_LEVEL1, 34'h80);
    wr(htu_pkg::ADDR_OFFS1, 32'h10, htu_pkg::RESP_OKAY);
    rd(htu_pkg::ADDR_LEVEL1, 34'h90);
    wr(8'h40, 32'h0, htu_pkg::RESP_SLVERR);
    rd(8'h40, {htu_pkg::RESP_SLVERR, 32'h0});
    acq(32'h0021, 8'h10, 8'h10, 8'h10, 1'b0, 0, 1000);
    acq(32'h0b21, 8'h10, 8'ha0, 8'h10, 1'b0, 1, 0);
    acq(32'h0123, 8'h10, 8'h10, 8'ha0, 1'b0, 1, 0);
    acq(32'h0125, 8'h10, 8'ha0, 8'h10, 1'b0, 0, 1500);
    acq(32'h0125, 8'h10, 8'ha0, 8'ha0, 1'b0, 1, 0);
    acq(32'h0127, 8'h10, 8'h10, 8'ha0, 1'b0, 1, 0);
    acq(32'h0129, 8'h10, 8'h10, 8'h10, 1'b1, 1, 0);
    wr(htu_pkg::ADDR_SLOPE, 32'h0, htu_pkg::RESP_OKAY);
    rd(htu_pkg::ADDR_SLOPE, 34'h1);
    acq(32'h0b21, 8'hf0, 8'h10, 8'h10, 1'b0, 1, 0);
    // eight records, slope falling, both fired latches from the last acquisition
    rd(htu_pkg::ADDR_STATUS, 34'h80058);
    test_done;
  end
  // watchdog: the sequence needs about 17000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    test_done;
  end
endmodule
